// ### logic/p2s_regs.svh
// Offsets, field positions, reset values and strap defaults of the port 2
// flow-control and energy-efficient strap loader.
// Included by the loader; holds definitions only.
`ifndef P2S_REGS_SVH
`define P2S_REGS_SVH

// Byte offsets on the register bus.
`define P2S_FLOW_CTRL_OFS      8'h00
`define P2S_AUTONEG_ADV_OFS    8'h04
`define P2S_MAC_TX_CFG_OFS     8'h08
`define P2S_PWRDN_XOVER_OFS    8'h0c
`define P2S_EEE_CAP_OFS        8'h10
`define P2S_EEE_ADV_OFS        8'h14
`define P2S_STRAP_STAT_OFS     8'h18

// Field positions.
`define P2S_BP_EN_BIT          0
`define P2S_TX_PAUSE_BIT       1
`define P2S_RX_PAUSE_BIT       2
`define P2S_MANUAL_FC_BIT      3
`define P2S_SYM_PAUSE_BIT      10
`define P2S_ASYM_PAUSE_BIT     11
`define P2S_MAC_EEE_BIT        0
`define P2S_PHY_EEE_BIT        0
`define P2S_EEE_100TX_BIT      1
`define P2S_FX_MODE_BIT        5

// Reset values of the bits before the straps are loaded.
`define P2S_BIT_RESET          1'b0

// Strap defaults when no strap source supplies a value.
`define P2S_BP_STRAP_DFLT      1'b1
`define P2S_FD_FC_STRAP_DFLT   1'b1
`define P2S_MAN_FC_STRAP_DFLT  1'b0

`endif

// ### logic/p2s_pkg.sv
// Types shared by the port 2 strap loader.
// No assumptions on the surroundings.
package p2s_pkg;

  typedef enum logic [1:0] {
    P2S_ST_LOAD = 2'b01,
    P2S_ST_RUN  = 2'b10
  } p2s_state_e;

  typedef logic [7:0] p2s_addr_t;

endpackage : p2s_pkg

// ### logic/p2s_bit.sv
// One register bit whose default is loaded from a strap after reset.
// Assumes load and write are one-cycle strobes in the clock domain.
`timescale 1ns/1ns
module p2s_bit #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Strap load
  input  wire logic load,
  input  wire logic load_val,
  // Software write
  input  wire logic wr,
  input  wire logic wr_val,
  // Stored value
  output logic      q
);

  // A load only happens right after reset, so it takes priority.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= RESET_VAL;
    end else if (load) begin
      q <= load_val;
    end else if (wr) begin
      q <= wr_val;
    end
  end

endmodule : p2s_bit

// ### logic/p2s_top.sv
// Port 2 strap loader: turns the port 2 and internal PHY B straps into the
// reset defaults of the flow-control and energy-efficient register bits,
// and lets software overwrite them, except the capability bit, over a classic Wishbone slave.
// Assumes the strap inputs are stable from reset release onward.
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`include "p2s_regs.svh"
module p2s_top
  import p2s_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Straps and mode
  input  wire logic        strap_valid,
  input  wire logic        p2_backpressure_strap,
  input  wire logic        p2_full_duplex_pause_strap,
  input  wire logic        p2_manual_pause_strap,
  input  wire logic        p2_energy_efficient_strap,
  input  wire logic        energy_efficient_enable_pin,
  input  wire logic        phy_fx_mode,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Register bits towards MAC and PHY
  output logic             p2_backpressure_enable,
  output logic             p2_tx_pause_enable,
  output logic             p2_rx_pause_enable,
  output logic             p2_manual_flow_ctrl,
  output logic             phy_adv_sym_pause,
  output logic             phy_adv_asym_pause,
  output logic             mac_energy_efficient_enable,
  output logic             phy_energy_efficient_enable,
  output logic             phy_energy_efficient_capability,
  output logic             phy_energy_efficient_advertise,
  output logic             p2_eee_active,
  output logic             loaded
);

  ////////////////////////////////////////////////////////////////////////////
  // Strap selection and derived defaults

  p2s_state_e state_r;
  p2s_state_e state_nxt;
  logic       load;
  logic       bp_s;
  logic       fd_s;
  logic       man_s;
  logic       eee_s;
  logic       asym_dflt;
  logic       sym_dflt;
  logic       phy_eee_dflt;

  // With no strap source the documented defaults apply; the energy-efficient
  // strap follows its dedicated pin instead of a fixed value.
  always_comb begin
    bp_s  = strap_valid ? p2_backpressure_strap : `P2S_BP_STRAP_DFLT;
    fd_s  = strap_valid ? p2_full_duplex_pause_strap : `P2S_FD_FC_STRAP_DFLT;
    man_s = strap_valid ? p2_manual_pause_strap : `P2S_MAN_FC_STRAP_DFLT;
    eee_s = strap_valid ? p2_energy_efficient_strap
                        : energy_efficient_enable_pin;
  end

  always_comb begin
    sym_dflt  = !phy_fx_mode && !man_s;
    asym_dflt = !phy_fx_mode && !man_s && fd_s;
  end

  // PHY energy-efficient defaults, void in fiber mode.
  always_comb begin
    phy_eee_dflt = !phy_fx_mode && eee_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load sequencing

  always_comb begin
    case (state_r)
      P2S_ST_LOAD: state_nxt = P2S_ST_RUN;
      P2S_ST_RUN:  state_nxt = P2S_ST_RUN;
      default:     state_nxt = P2S_ST_LOAD;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= P2S_ST_LOAD;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign load = (state_r == P2S_ST_LOAD);

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone access

  logic ack_r;
  logic req;
  logic wr;
  logic wr_lo;
  logic wr_hi;
  logic [31:0] rd_nxt;

  // The request is only answered after the straps are in place, so a read
  // never sees the pre-load reset values.
  assign req   = wb_cyc_i && wb_stb_i && !load;
  // A write lands on the edge where the master samples ack.
  assign wr    = req && wb_we_i && ack_r;
  assign wr_lo = wr && wb_sel_i[0];
  assign wr_hi = wr && wb_sel_i[1];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bits

  logic bp_q;
  logic txp_q;
  logic rxp_q;
  logic man_q;
  logic sym_q;
  logic asym_q;
  logic mac_eee_q;
  logic phy_eee_q;
  logic adv_eee_q;

  p2s_bit #(.RESET_VAL(`P2S_BIT_RESET)) u_bp (
    .clock    (clock),
    .rst_n    (rst_n),
    .load     (load),
    .load_val (bp_s),
    .wr       (wr_lo && wb_adr_i == `P2S_FLOW_CTRL_OFS),
    .wr_val   (wb_dat_i[`P2S_BP_EN_BIT]),
    .q        (bp_q)
  );

  p2s_bit #(.RESET_VAL(`P2S_BIT_RESET)) u_txp (
    .clock    (clock),
    .rst_n    (rst_n),
    .load     (load),
    .load_val (fd_s),
    .wr       (wr_lo && wb_adr_i == `P2S_FLOW_CTRL_OFS),
    .wr_val   (wb_dat_i[`P2S_TX_PAUSE_BIT]),
    .q        (txp_q)
  );

  p2s_bit #(.RESET_VAL(`P2S_BIT_RESET)) u_rxp (
    .clock    (clock),
    .rst_n    (rst_n),
    .load     (load),
    .load_val (fd_s),
    .wr       (wr_lo && wb_adr_i == `P2S_FLOW_CTRL_OFS),
    .wr_val   (wb_dat_i[`P2S_RX_PAUSE_BIT]),
    .q        (rxp_q)
  );

  p2s_bit #(.RESET_VAL(`P2S_BIT_RESET)) u_man (
    .clock    (clock),
    .rst_n    (rst_n),
    .load     (load),
    .load_val (man_s),
    .wr       (wr_lo && wb_adr_i == `P2S_FLOW_CTRL_OFS),
    .wr_val   (wb_dat_i[`P2S_MANUAL_FC_BIT]),
    .q        (man_q)
  );

  p2s_bit #(.RESET_VAL(`P2S_BIT_RESET)) u_sym (
    .clock    (clock),
    .rst_n    (rst_n),
    .load     (load),
    .load_val (sym_dflt),
    .wr       (wr_hi && wb_adr_i == `P2S_AUTONEG_ADV_OFS),
    .wr_val   (wb_dat_i[`P2S_SYM_PAUSE_BIT]),
    .q        (sym_q)
  );

  p2s_bit #(.RESET_VAL(`P2S_BIT_RESET)) u_asym (
    .clock    (clock),
    .rst_n    (rst_n),
    .load     (load),
    .load_val (asym_dflt),
    .wr       (wr_hi && wb_adr_i == `P2S_AUTONEG_ADV_OFS),
    .wr_val   (wb_dat_i[`P2S_ASYM_PAUSE_BIT]),
    .q        (asym_q)
  );

  p2s_bit #(.RESET_VAL(`P2S_BIT_RESET)) u_mac_eee (
    .clock    (clock),
    .rst_n    (rst_n),
    .load     (load),
    .load_val (eee_s),
    .wr       (wr_lo && wb_adr_i == `P2S_MAC_TX_CFG_OFS),
    .wr_val   (wb_dat_i[`P2S_MAC_EEE_BIT]),
    .q        (mac_eee_q)
  );

  p2s_bit #(.RESET_VAL(`P2S_BIT_RESET)) u_phy_eee (
    .clock    (clock),
    .rst_n    (rst_n),
    .load     (load),
    .load_val (phy_eee_dflt),
    .wr       (wr_lo && wb_adr_i == `P2S_PWRDN_XOVER_OFS),
    .wr_val   (wb_dat_i[`P2S_PHY_EEE_BIT]),
    .q        (phy_eee_q)
  );

  p2s_bit #(.RESET_VAL(`P2S_BIT_RESET)) u_adv_eee (
    .clock    (clock),
    .rst_n    (rst_n),
    .load     (load),
    .load_val (phy_eee_dflt),
    .wr       (wr_lo && wb_adr_i == `P2S_EEE_ADV_OFS),
    .wr_val   (wb_dat_i[`P2S_EEE_100TX_BIT]),
    .q        (adv_eee_q)
  );

  // Capability is read-only, so software cannot claim an ability the PHY
  // was not strapped for.
  // Capability from strap.
  p2s_bit #(.RESET_VAL(`P2S_BIT_RESET)) u_cap_eee (
    .clock    (clock),
    .rst_n    (rst_n),
    .load     (load),
    .load_val (phy_eee_dflt),
    .wr       (1'b0),
    .wr_val   (1'b0),
    .q        (phy_energy_efficient_capability)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (wb_adr_i)
      `P2S_FLOW_CTRL_OFS: begin
        rd_nxt[`P2S_BP_EN_BIT]     = bp_q;
        rd_nxt[`P2S_TX_PAUSE_BIT]  = txp_q;
        rd_nxt[`P2S_RX_PAUSE_BIT]  = rxp_q;
        rd_nxt[`P2S_MANUAL_FC_BIT] = man_q;
      end
      `P2S_AUTONEG_ADV_OFS: begin
        rd_nxt[`P2S_SYM_PAUSE_BIT]  = sym_q;
        rd_nxt[`P2S_ASYM_PAUSE_BIT] = asym_q;
      end
      `P2S_MAC_TX_CFG_OFS:  rd_nxt[`P2S_MAC_EEE_BIT] = mac_eee_q;
      `P2S_PWRDN_XOVER_OFS: rd_nxt[`P2S_PHY_EEE_BIT] = phy_eee_q;
      `P2S_EEE_CAP_OFS: begin
        rd_nxt[`P2S_EEE_100TX_BIT] = phy_energy_efficient_capability;
      end
      `P2S_EEE_ADV_OFS:     rd_nxt[`P2S_EEE_100TX_BIT] = adv_eee_q;
      `P2S_STRAP_STAT_OFS: begin
        rd_nxt[4:0] = {eee_s, man_s, fd_s, bp_s, strap_valid};
        rd_nxt[`P2S_FX_MODE_BIT] = phy_fx_mode;
      end
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !ack_r) begin
      wb_dat_o <= rd_nxt;
    end
  end

  assign wb_ack_o = ack_r;

  ////////////////////////////////////////////////////////////////////////////
  // Output stage

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      p2_backpressure_enable      <= 1'b0;
      p2_tx_pause_enable          <= 1'b0;
      p2_rx_pause_enable          <= 1'b0;
      p2_manual_flow_ctrl         <= 1'b0;
      phy_adv_sym_pause           <= 1'b0;
      phy_adv_asym_pause          <= 1'b0;
      mac_energy_efficient_enable <= 1'b0;
      phy_energy_efficient_enable <= 1'b0;
      phy_energy_efficient_advertise <= 1'b0;
      loaded                      <= 1'b0;
    end else begin
      p2_backpressure_enable      <= bp_q;
      p2_tx_pause_enable          <= txp_q;
      p2_rx_pause_enable          <= rxp_q;
      p2_manual_flow_ctrl         <= man_q;
      phy_adv_sym_pause           <= sym_q;
      phy_adv_asym_pause          <= asym_q;
      mac_energy_efficient_enable <= mac_eee_q;
      phy_energy_efficient_enable <= phy_eee_q;
      phy_energy_efficient_advertise <= adv_eee_q;
      loaded                      <= !load;
    end
  end

  // A fiber link has no auto-negotiation result, so energy-efficient
  // operation stays off there whatever software writes.
  // Fiber mode gating.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      p2_eee_active <= 1'b0;
    end else begin
      p2_eee_active <= mac_eee_q && phy_eee_q && !phy_fx_mode;
    end
  end

endmodule : p2s_top

// ### dv/p2s_props.sv
// Assertions on the ports of the port 2 strap loader.
// Bound into p2s_top; straps stay steady once reset is released.
`timescale 1ns/1ns
module p2s_props (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Straps and mode
  input wire logic strap_valid,
  input wire logic p2_backpressure_strap,
  input wire logic p2_full_duplex_pause_strap,
  input wire logic p2_manual_pause_strap,
  input wire logic p2_energy_efficient_strap,
  input wire logic energy_efficient_enable_pin,
  input wire logic phy_fx_mode,
  // Bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Register bits
  input wire logic p2_backpressure_enable,
  input wire logic p2_tx_pause_enable,
  input wire logic p2_rx_pause_enable,
  input wire logic p2_manual_flow_ctrl,
  input wire logic phy_adv_sym_pause,
  input wire logic phy_adv_asym_pause,
  input wire logic mac_energy_efficient_enable,
  input wire logic phy_energy_efficient_enable,
  input wire logic phy_energy_efficient_advertise,
  input wire logic p2_eee_active,
  input wire logic loaded
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////////
  // Straps as they stand after the fallback defaults.
  wire bp = strap_valid ? p2_backpressure_strap : 1'b1;
  wire fd = strap_valid ? p2_full_duplex_pause_strap : 1'b1;
  wire mn = strap_valid ? p2_manual_pause_strap : 1'b0;
  wire ee = strap_valid ? p2_energy_efficient_strap
                        : energy_efficient_enable_pin;
  wire fx = phy_fx_mode;

  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  bp_load_a: assert property ($rose(loaded) |-> p2_backpressure_enable == bp)
    else $error("backpressure default wrong");
  fd_load_a: assert property ($rose(loaded) |->
    p2_tx_pause_enable == fd && p2_rx_pause_enable == fd)
    else $error("pause enable default wrong");
  asym_load_a: assert property ($rose(loaded) |->
    phy_adv_asym_pause == (fd && !mn && !fx))
    else $error("asymmetric pause default wrong");
  man_load_a: assert property ($rose(loaded) |->
    p2_manual_flow_ctrl == mn && phy_adv_sym_pause == (!mn && !fx))
    else $error("manual select default wrong");
  mac_eee_a: assert property ($rose(loaded) |->
    mac_energy_efficient_enable == ee)
    else $error("mac eee default wrong");
  phy_eee_a: assert property ($rose(loaded) |->
    phy_energy_efficient_enable == (ee && !fx) &&
    phy_energy_efficient_advertise == (ee && !fx))
    else $error("phy eee default wrong");
  eee_gate_a: assert property (p2_eee_active |-> $past(!phy_fx_mode) &&
    mac_energy_efficient_enable && phy_energy_efficient_enable)
    else $error("eee active without cause");
  load_hold_a: assert property (loaded |=> loaded)
    else $error("loaded dropped");
endmodule : p2s_props

bind p2s_top p2s_props p2s_props_inst (.*);

// ### dv/p2s_top_test.sv
// Self-checking bench of the port 2 strap loader.
// Drives straps and a classic Wishbone master itself.
`timescale 1ns/1ns
module p2s_top_test;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        strap_valid = 1'b0;
  logic        p2_backpressure_strap = 1'b0;
  logic        p2_full_duplex_pause_strap = 1'b0;
  logic        p2_manual_pause_strap = 1'b0;
  logic        p2_energy_efficient_strap = 1'b0;
  logic        energy_efficient_enable_pin = 1'b0;
  logic        phy_fx_mode = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, p2_backpressure_enable, p2_tx_pause_enable;
  logic        p2_rx_pause_enable, p2_manual_flow_ctrl, phy_adv_sym_pause;
  logic        phy_adv_asym_pause, mac_energy_efficient_enable;
  logic        phy_energy_efficient_enable, phy_energy_efficient_capability;
  logic        phy_energy_efficient_advertise, p2_eee_active, loaded;
  int          fails = 0;
  int          n_compared = 0;
  int          cycles = 0;

  p2s_top p2s_top_inst (.*);

  always #50 clock = ~clock;
  //////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 4'hf, 32'h0, q);
    check($sformatf("reg %h", a), q, e);
  endtask : rd

  // Strap order is valid, bp, fd, manual, eee, pin, fiber.
  task automatic do_reset(input logic [6:0] s);
    @(posedge clock);
    rst_n <= 1'b0;
    {strap_valid, p2_backpressure_strap, p2_full_duplex_pause_strap,
     p2_manual_pause_strap, p2_energy_efficient_strap,
     energy_efficient_enable_pin, phy_fx_mode} <= s;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
  endtask : do_reset
  //////////////////////////////////////////////////////////////////////////////
  // Every strap default.
  task automatic t_defaults;
    logic [6:0] tbl [6] = '{7'h00, 7'h03, 7'h40, 7'h7c, 7'h6d, 7'h51};
    logic       sv, bp, fd, mn, ee, pin, fx, pa;
    foreach (tbl[k]) begin
      {sv, bp, fd, mn, ee, pin, fx} = tbl[k];
      do_reset(tbl[k]);
      bp = sv ? bp : 1'b1;
      fd = sv ? fd : 1'b1;
      mn = sv ? mn : 1'b0;
      ee = sv ? ee : pin;
      pa = !fx && !mn;
      rd(8'h00, {28'h0, mn, fd, fd, bp});
      rd(8'h04, {20'h0, pa && fd, pa, 10'h0});
      rd(8'h08, {31'h0, ee});
      rd(8'h0c, {31'h0, ee && !fx});
      rd(8'h10, {30'h0, ee && !fx, 1'b0});
      rd(8'h14, {30'h0, ee && !fx, 1'b0});
      rd(8'h18, {26'h0, fx, ee, mn, fd, bp, sv});
      check("eee active", 32'(p2_eee_active), 32'(ee && !fx));
    end
  endtask : t_defaults

  task automatic t_override;
    logic [31:0] q;
    do_reset(7'h74);
    wb(1'b1, 8'h00, 4'h1, 32'h0000000a, q);
    wb(1'b1, 8'h04, 4'h1, 32'h0, q);
    wb(1'b1, 8'h08, 4'hf, 32'h0, q);
    wb(1'b1, 8'h10, 4'hf, 32'h0, q);
    wb(1'b1, 8'h18, 4'hf, 32'h0, q);
    repeat (2) @(posedge clock);
    check("bp out", 32'(p2_backpressure_enable), 32'h0);
    check("eee active", 32'(p2_eee_active), 32'h0);
    rd(8'h00, 32'h0000000a);
    rd(8'h04, 32'h00000c00);
    rd(8'h10, 32'h00000002);
    rd(8'h18, 32'h00000017);
    rd(8'h40, 32'h0);
    wb(1'b1, 8'h04, 4'h2, 32'h00000400, q);
    wb(1'b1, 8'h14, 4'h1, 32'h0, q);
    rd(8'h04, 32'h00000400);
    rd(8'h14, 32'h0);
    do_reset(7'h74);
    rd(8'h00, 32'h00000007);
    rd(8'h04, 32'h00000c00);
    // In fiber mode a software-set PHY enable must not activate the port.
    do_reset(7'h7d);
    wb(1'b1, 8'h0c, 4'h1, 32'h00000001, q);
    repeat (2) @(posedge clock);
    check("phy eee out", 32'(phy_energy_efficient_enable), 32'h1);
    check("eee active", 32'(p2_eee_active), 32'h0);
  endtask : t_override

  initial begin
    t_defaults();
    t_override();
    close_out();
  end
endmodule : p2s_top_test
